// [verilog/crs_regs.sv]
// module: cpu register set with fetch sequencing and memory access
`timescale 1ns/10ps
// Overview of operation
// - 24-bit accumulator, arithmetic, shift, io data
// - accumulator low byte read/written as pseudoregister
// - 24-bit extension register extends accumulator
// - 47-bit double: extension high, accumulator low
// - three 24-bit general registers, usable index
// - 4-bit condition register written and read
// - 16-bit program counter holds fetch address
// - counter changes only by branch, panel or step after fetch
// - fetched instruction latched whole; execution loads only the shift count
// - instruction bits 7..0 are shift count
// - direct address from instruction bits 14..0
// - counter top bit ORed into address bit 15
// - execution confined below 64K words
// - indexing to 64K words, bytes 192K
// - programmed io moves 8 or 24 bits
// - memory in 48-bit double words, parity checked
// - indexed address adds selected index register
// - upper-section bias still applies when indexed
module crs_regs #(
    parameter int WORD_W = crs_pkg::WORD_W           // data word width
) (
    input  wire logic                        clk_i,          // 250 MHz core clock
    input  wire logic                        reset_i,        // async reset, active high
    // execution side
    input  wire logic                        fetch_i,        // request next instruction
    input  wire logic                        wr_en_i,        // register write strobe
    input  wire logic [3:0]                  wr_sel_i,       // register write select
    input  wire logic [46:0]                 wr_data_i,      // write data (double width)
    input  wire logic [3:0]                  rd_sel_i,       // register read select
    input  wire logic                        shift_load_i,   // load shift count
    input  wire logic [7:0]                  shift_cnt_i,    // new shift count
    input  wire logic                        branch_i,       // branch taken
    input  wire logic [15:0]                 branch_addr_i,  // branch target
    input  wire logic                        panel_pc_i,     // panel entry of counter
    input  wire logic [15:0]                 panel_data_i,   // panel counter value
    input  wire logic                        opnd_rd_i,      // operand read request
    input  wire logic                        opnd_wr_i,      // operand write request
    input  wire logic                        indexed_i,      // indexed reference
    input  wire logic                        byte_mode_i,    // byte indexed reference
    input  wire logic [47:0]                 opnd_wdata_i,   // operand write data
    // peripheral side
    input  wire logic [23:0]                 io_in_i,        // programmed io input
    output logic      [23:0]                 io_out_o,       // programmed io output
    output logic                             io_strobe_o,    // io output valid pulse
    // memory side
    output logic      [17:0]                 mem_addr_o,     // double word address
    output logic                             mem_rd_o,       // memory read strobe
    output logic                             mem_wr_o,       // memory write strobe
    output logic      [47:0]                 mem_wdata_o,    // write double word
    output logic                             mem_wpar_o,     // write data parity
    input  wire logic [47:0]                 mem_rdata_i,    // read double word
    input  wire logic                        mem_rpar_i,     // read parity bit
    input  wire logic                        mem_ack_i,      // memory access done
    // status outputs
    output logic      [46:0]                 rd_data_o,      // register read data
    output logic      [23:0]                 instr_o,        // instruction register
    output logic      [7:0]                  shift_cnt_o,    // shift count field
    output logic      [15:0]                 pc_o,           // program counter
    output logic      [47:0]                 opnd_rdata_o,   // operand read data
    output logic                             opnd_done_o,    // operand access done pulse
    output logic                             instr_valid_o,  // instruction ready level
    output logic                             parity_err_o,   // sticky parity error
    output logic                             range_err_o     // address reach error pulse
);
    // ==========================================================
    // register storage
    logic [23:0] acc_reg;                            // accumulator
    logic [23:0] ext_reg;                            // extension register
    logic [23:0] ix_reg [3];                         // general/index registers
    logic [3:0]  cond_reg;                           // condition register
    logic [15:0] pc_reg;                             // program counter
    logic [23:0] ir_reg;                             // instruction register
    crs_pkg::crs_state_t st_reg;                     // fetch state
    logic        fetch_hi_reg;                       // fetched word is odd half
    logic        opnd_busy_reg;                      // operand access pending
    logic        opnd_wr_reg;                        // pending access is a write
    logic [46:0] dbl;                                // double pseudoregister view
    logic        rpar_ok;                            // read parity matches

    crs_addr_if ai ();                               // address formation link

    // ==========================================================
    // address unit hookup
    assign ai.instr     = ir_reg;
    assign ai.pc        = pc_reg;
    assign ai.ix1       = ix_reg[0];
    assign ai.ix2       = ix_reg[1];
    assign ai.ix3       = ix_reg[2];
    assign ai.indexed   = indexed_i;
    assign ai.byte_mode = byte_mode_i;

    crs_addr_unit u_addr (
        .a (ai.unit)
    );

    // double view: accumulator bit 23 left out
    assign dbl     = {ext_reg, acc_reg[crs_pkg::ACC_TOP-1:0]};
    // odd parity over the double word
    assign rpar_ok = ^{mem_rdata_i, mem_rpar_i};

    // ==========================================================
    // accumulator and extension writes
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg <= crs_pkg::WORD_RST;
            ext_reg <= crs_pkg::WORD_RST;
        end else if (wr_en_i) begin
            case (wr_sel_i)
                crs_pkg::CRS_SEL_ACC: begin
                    acc_reg <= wr_data_i[23:0];
                end
                crs_pkg::CRS_SEL_BYTE: begin
                    acc_reg[crs_pkg::SHIFT_MSB:0] <= wr_data_i[7:0];
                end
                crs_pkg::CRS_SEL_EXT: begin
                    ext_reg <= wr_data_i[23:0];
                end
                crs_pkg::CRS_SEL_DBL: begin
                    // split double; accumulator top bit kept
                    ext_reg <= wr_data_i[46:23];
                    acc_reg[22:0] <= wr_data_i[22:0];
                end
                crs_pkg::CRS_SEL_IO8: begin
                    acc_reg[7:0] <= io_in_i[7:0];
                end
                crs_pkg::CRS_SEL_IO24: begin
                    acc_reg <= io_in_i;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // general/index registers, one per generate slot
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ix
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    ix_reg[gi] <= crs_pkg::WORD_RST;
                end else if (wr_en_i && wr_sel_i == 4'(crs_pkg::CRS_SEL_IX1) + 4'(gi)) begin
                    ix_reg[gi] <= wr_data_i[23:0];
                end
            end
        end
    endgenerate

    // ==========================================================
    // condition register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cond_reg <= crs_pkg::COND_RST;
        end else if (wr_en_i && wr_sel_i == crs_pkg::CRS_SEL_COND) begin
            cond_reg <= wr_data_i[3:0];
        end
    end

    // ==========================================================
    // program counter: panel, branch, else step after fetch
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_reg <= crs_pkg::PC_RST;
        end else if (panel_pc_i) begin
            pc_reg <= panel_data_i;
        end else if (branch_i) begin
            pc_reg <= branch_addr_i;
        end else if (st_reg == crs_pkg::CRS_ST_FETCH && mem_ack_i) begin
            // 16-bit wrap keeps execution below 64K
            pc_reg <= pc_reg + 16'h0001;
        end
    end

    // ==========================================================
    // fetch sequencer and instruction register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= crs_pkg::CRS_ST_IDLE;
            ir_reg <= crs_pkg::WORD_RST;
        end else begin
            case (st_reg)
                crs_pkg::CRS_ST_IDLE: begin
                    if (fetch_i && !opnd_busy_reg) begin
                        st_reg <= crs_pkg::CRS_ST_FETCH;
                    end
                end
                crs_pkg::CRS_ST_FETCH: begin
                    if (mem_ack_i) begin
                        // pick word from double, latch whole
                        ir_reg <= fetch_hi_reg ? mem_rdata_i[47:24] : mem_rdata_i[23:0];
                        st_reg <= crs_pkg::CRS_ST_EXEC;
                    end
                end
                crs_pkg::CRS_ST_EXEC: begin
                    if (shift_load_i) begin
                        ir_reg[crs_pkg::SHIFT_MSB:0] <= shift_cnt_i;
                    end
                    // no fetch while an operand access is still pending
                    if (fetch_i && !opnd_busy_reg) begin
                        st_reg <= crs_pkg::CRS_ST_FETCH;
                    end
                end
                default: begin
                    st_reg <= crs_pkg::CRS_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // memory access strobes and addressing
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_addr_o    <= 18'h00000;
            mem_rd_o      <= 1'b0;
            mem_wr_o      <= 1'b0;
            mem_wdata_o   <= 48'h000000000000;
            mem_wpar_o    <= 1'b0;
            fetch_hi_reg  <= 1'b0;
            opnd_busy_reg <= 1'b0;
            opnd_wr_reg   <= 1'b0;
            range_err_o   <= 1'b0;
        end else begin
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            range_err_o <= 1'b0;
            if (mem_ack_i) begin
                opnd_busy_reg <= 1'b0;
            end
            if (fetch_i && st_reg != crs_pkg::CRS_ST_FETCH && !opnd_busy_reg) begin
                // double word holding the counter's word
                mem_addr_o   <= {3'b000, pc_reg[15:1]};
                fetch_hi_reg <= pc_reg[0];
                mem_rd_o     <= 1'b1;
            end else if ((opnd_rd_i || opnd_wr_i) && st_reg == crs_pkg::CRS_ST_EXEC
                         && !opnd_busy_reg) begin
                if (ai.range_err) begin
                    range_err_o <= 1'b1;
                end else begin
                    // word address formed by address unit
                    mem_addr_o    <= {1'b0, ai.addr[17:1]};
                    mem_rd_o      <= opnd_rd_i;
                    mem_wr_o      <= opnd_wr_i;
                    mem_wdata_o   <= opnd_wdata_i;
                    mem_wpar_o    <= ~^opnd_wdata_i;
                    opnd_busy_reg <= 1'b1;
                    opnd_wr_reg   <= opnd_wr_i;
                end
            end
        end
    end

    // ==========================================================
    // operand completion and parity check
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            opnd_rdata_o <= 48'h000000000000;
            opnd_done_o  <= 1'b0;
            parity_err_o <= 1'b0;
        end else begin
            opnd_done_o <= opnd_busy_reg && mem_ack_i;
            if (opnd_busy_reg && mem_ack_i && !opnd_wr_reg) begin
                opnd_rdata_o <= mem_rdata_i;
            end
            // every read answer is checked, fetches included
            if (mem_ack_i && !(opnd_busy_reg && opnd_wr_reg) && !rpar_ok) begin
                parity_err_o <= 1'b1;
            end
        end
    end

    // ==========================================================
    // register read port and status outputs
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o     <= 47'h0;
            io_out_o      <= crs_pkg::WORD_RST;
            io_strobe_o   <= 1'b0;
            instr_o       <= crs_pkg::WORD_RST;
            shift_cnt_o   <= 8'h00;
            pc_o          <= crs_pkg::PC_RST;
            instr_valid_o <= 1'b0;
        end else begin
            if (rd_sel_i == crs_pkg::CRS_SEL_ACC) begin
                rd_data_o <= {23'h0, acc_reg};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_BYTE) begin
                rd_data_o <= {39'h0, acc_reg[7:0]};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_EXT) begin
                rd_data_o <= {23'h0, ext_reg};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_DBL) begin
                rd_data_o <= dbl;
            end else if (rd_sel_i == crs_pkg::CRS_SEL_IX1) begin
                rd_data_o <= {23'h0, ix_reg[0]};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_IX2) begin
                rd_data_o <= {23'h0, ix_reg[1]};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_IX3) begin
                rd_data_o <= {23'h0, ix_reg[2]};
            end else if (rd_sel_i == crs_pkg::CRS_SEL_COND) begin
                rd_data_o <= {43'h0, cond_reg};
            end else begin
                rd_data_o <= 47'h0;                         // counter not readable
            end
            // io output: 8-bit select sends byte only
            io_strobe_o <= 1'b0;
            if (rd_sel_i == crs_pkg::CRS_SEL_IO8 && !wr_en_i) begin
                io_out_o    <= {16'h0000, acc_reg[7:0]};
                io_strobe_o <= 1'b1;
            end else if (rd_sel_i == crs_pkg::CRS_SEL_IO24 && !wr_en_i) begin
                io_out_o    <= acc_reg;
                io_strobe_o <= 1'b1;
            end
            instr_o       <= ir_reg;
            shift_cnt_o   <= ir_reg[crs_pkg::SHIFT_MSB:0];
            pc_o          <= pc_reg;
            instr_valid_o <= (st_reg == crs_pkg::CRS_ST_EXEC);
        end
    end
endmodule

// [pkg/crs_pkg.sv]
// package: register widths, field positions, reset values and command codes of the cpu register set
package crs_pkg;
    // ==========================================================
    // widths
    localparam int WORD_W      = 24;                 // data word width
    localparam int BYTE_W      = 8;                  // byte pseudoregister width
    localparam int DBL_W       = 47;                 // double pseudoregister width
    localparam int COND_W      = 4;                  // condition register width
    localparam int PC_W        = 16;                 // program counter width
    localparam int MEM_W       = 48;                 // memory double word width
    localparam int MADDR_W     = 18;                 // memory word address width (256K)
    localparam int DIRECT_W    = 15;                 // direct address field width
    localparam int BYTE_ADDR_W = 18;                 // byte index reach (192K bytes)
    // ==========================================================
    // field positions
    localparam int DIRECT_MSB  = 14;                 // top bit of direct address field
    localparam int SHIFT_MSB   = 7;                  // top bit of shift count field
    localparam int XSEL_LSB    = 15;                 // index select field low bit
    localparam int PC_TOP      = 15;                 // program counter top bit
    localparam int ACC_TOP     = 23;                 // accumulator bit left out of double
    // ==========================================================
    // reset values
    localparam logic [23:0] WORD_RST = 24'h000000;   // data registers after reset
    localparam logic [3:0]  COND_RST = 4'h0;         // condition register after reset
    localparam logic [15:0] PC_RST   = 16'h0000;     // program counter after reset
    localparam logic [15:0] UPPER_BIAS = 16'h8000;   // upper section bias, octal 100000
    localparam logic [17:0] BYTE_LIMIT = 18'h30000;  // 192K byte indexed limit
    // ==========================================================
    // register select codes for the execution write and read ports
    typedef enum logic [3:0] {
        CRS_SEL_ACC  = 4'h0,                         // accumulator
        CRS_SEL_BYTE = 4'h1,                         // accumulator bits 7..0
        CRS_SEL_EXT  = 4'h2,                         // extension register
        CRS_SEL_DBL  = 4'h3,                         // double pseudoregister
        CRS_SEL_IX1  = 4'h4,                         // first general/index
        CRS_SEL_IX2  = 4'h5,                         // second general/index
        CRS_SEL_IX3  = 4'h6,                         // third general/index
        CRS_SEL_COND = 4'h7,                         // condition register
        CRS_SEL_IO8  = 4'h8,                         // 8-bit programmed transfer
        CRS_SEL_IO24 = 4'h9                          // 24-bit programmed transfer
    } crs_sel_t;
    // ==========================================================
    // fetch state machine codes
    typedef enum logic [2:0] {
        CRS_ST_IDLE  = 3'b001,                       // waiting for fetch request
        CRS_ST_FETCH = 3'b010,                       // memory read pending
        CRS_ST_EXEC  = 3'b100                        // instruction held for execution
    } crs_state_t;
endpackage

// [pkg/crs_addr_if.sv]
// interface: address formation request and result between the register set and its address unit
`timescale 1ns/10ps
interface crs_addr_if;
    logic [23:0] instr;                              // instruction word
    logic [15:0] pc;                                 // current program counter
    logic [23:0] ix1;                                // first index register
    logic [23:0] ix2;                                // second index register
    logic [23:0] ix3;                                // third index register
    logic        indexed;                            // indexing requested
    logic        byte_mode;                          // byte indexed reference
    logic [17:0] addr;                               // resulting word or byte address
    logic        range_err;                          // index beyond allowed reach
    modport regs (output instr, pc, ix1, ix2, ix3, indexed, byte_mode,
                  input  addr, range_err);
    modport unit (input  instr, pc, ix1, ix2, ix3, indexed, byte_mode,
                  output addr, range_err);
endinterface

// [verilog/crs_addr_unit.sv]
// module: direct, biased and indexed address formation
`timescale 1ns/10ps
module crs_addr_unit (
    crs_addr_if.unit a
);
    // ==========================================================
    // index register pick by the two-bit select field
    function automatic logic [23:0] pick_ix(input logic [1:0] s, input logic [23:0] r1,
                                            input logic [23:0] r2, input logic [23:0] r3);
        if (s == 2'd1) begin
            pick_ix = r1;
        end else if (s == 2'd2) begin
            pick_ix = r2;
        end else if (s == 2'd3) begin
            pick_ix = r3;
        end else begin
            pick_ix = 24'h000000;                    // select zero: no index
        end
    endfunction

    logic [15:0] direct;                             // biased direct address
    logic [23:0] ixv;                                // chosen index value
    logic [24:0] sum;                                // full width index sum

    // ==========================================================
    // combinational address formation
    always_comb begin
        // bias ORed into bit 15 above the 15-bit field
        direct = {a.pc[crs_pkg::PC_TOP], a.instr[crs_pkg::DIRECT_MSB:0]};
        ixv    = pick_ix(a.instr[crs_pkg::XSEL_LSB+1:crs_pkg::XSEL_LSB], a.ix1, a.ix2, a.ix3);
        // add instruction address to chosen index
        sum    = {9'h000, direct} + {1'b0, ixv};
        a.addr      = {2'b00, direct};
        a.range_err = 1'b0;
        if (a.indexed && a.byte_mode) begin
            // byte reach is 192K bytes
            a.addr      = sum[17:0];
            a.range_err = (sum >= {7'h00, crs_pkg::BYTE_LIMIT});
        end else if (a.indexed) begin
            // word indexing confined to 64K; upper bias keeps bit 15 set
            a.addr      = {2'b00, sum[15] | a.pc[crs_pkg::PC_TOP], sum[14:0]};
            a.range_err = (sum[24:16] != 9'h000);
        end
    end
endmodule

// [verification/crs_mem_model.sv]
// model: double word main memory answering fetch and operand accesses
`timescale 1ns/10ps
module crs_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [17:0] addr_i,
    output logic      [47:0] rdata_o = 48'h0,
    output logic             rpar_o = 1'b1,
    output logic             ack_o = 1'b0
);
    logic        slow = 1'b0;   // alternates prompt and slow answers
    logic [17:0] a;             // address captured with the request
    // answer each strobe with an address-tagged word, odd parity; bus garbled when idle
    always begin
        @(posedge clk_i);
        if (rd_i || wr_i) begin
            a = addr_i;
            slow = ~slow;
            repeat (slow ? 3 : 0) @(posedge clk_i);
            rdata_o <= {6'h15, a, 6'h2A, a};
            rpar_o <= ~^{6'h15, a, 6'h2A, a};
            ack_o <= 1'b1;
            @(posedge clk_i);
            {ack_o, rdata_o, rpar_o} <= {1'b0, ~rdata_o, ~rpar_o};
        end
    end
endmodule

// [verification/crs_regs_chk.sv]
// checker: port-level properties of the cpu register set
`timescale 1ns/10ps
module crs_regs_chk (
    input wire logic clk_i, reset_i, mem_ack_i, branch_i, panel_pc_i, wr_en_i,
    input wire logic mem_wr_o, mem_wpar_o, parity_err_o, instr_valid_o, opnd_done_o,
    input wire logic io_strobe_o,
    input wire logic [3:0] rd_sel_i,
    input wire logic [47:0] mem_wdata_o,
    input wire logic [15:0] pc_o,
    input wire logic [23:0] instr_o,
    input wire logic [7:0] shift_cnt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    pc_quiet_a: assert property (!(branch_i || panel_pc_i || mem_ack_i) [*3] |-> $stable(pc_o))
        else $error("pc moved without branch, panel or fetch");
    ir_hold_a: assert property ($changed(instr_o[23:8]) |-> $past(mem_ack_i) || $past(mem_ack_i, 2))
        else $error("instruction changed without fetch answer");
    valid_a: assert property ($rose(instr_valid_o) |-> $past(mem_ack_i, 2))
        else $error("instruction valid without fetch answer");
    shift_a: assert property (shift_cnt_o == instr_o[7:0])
        else $error("shift count differs from instruction low byte");
    parity_a: assert property (mem_wr_o |-> ^{mem_wdata_o, mem_wpar_o})
        else $error("write parity not odd");
    sticky_a: assert property (parity_err_o |=> parity_err_o)
        else $error("parity error flag dropped");
    done_a: assert property (opnd_done_o |-> $past(mem_ack_i) ##1 !opnd_done_o)
        else $error("operand done without memory answer");
    io_a: assert property (io_strobe_o |-> $past(rd_sel_i) inside {4'h8, 4'h9} && !$past(wr_en_i))
        else $error("io strobe without io read select");
    cover property (opnd_done_o);
    cover property (io_strobe_o);
    cover property ($rose(instr_valid_o));
endmodule

// [verification/tb_top.sv]
// testbench: register, io, fetch and operand sequences for the cpu register set
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 0, reset_i = 1, fetch_i = 0, wr_en_i = 0, shift_load_i = 0, branch_i = 0;
    logic panel_pc_i = 0, opnd_rd_i = 0, opnd_wr_i = 0, mem_rd_o, mem_wr_o, mem_wpar_o;
    logic mem_rpar_i, mem_ack_i, io_strobe_o, opnd_done_o, instr_valid_o, parity_err_o;
    logic range_err_o;
    logic [3:0]  wr_sel_i = 0, rd_sel_i = 0;
    logic [46:0] wr_data_i = 0, rd_data_o;
    logic [15:0] branch_addr_i = 0, panel_data_i = 0, pc_o;
    logic [23:0] io_in_i = 0, io_out_o, instr_o;
    logic [47:0] mem_wdata_o, mem_rdata_i, opnd_rdata_o;
    logic [17:0] mem_addr_o;
    logic [7:0]  shift_cnt_i = 0, shift_cnt_o;
    int          error_cnt = 0, checks = 0, cyc = 0;
    crs_regs i_crs_regs (.*, .indexed_i(1'b0), .byte_mode_i(1'b0), .opnd_wdata_i(48'h0A0B0C0D0E0F));
    crs_mem_model i_crs_mem_model (.clk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
        .rdata_o(mem_rdata_i), .rpar_o(mem_rpar_i), .ack_o(mem_ack_i));
    initial forever #2 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) if (++cyc == 2000) begin error_cnt++; finish_test(); end
    task automatic chk(input string nm, input logic [47:0] got, exp);
        checks++;
        if (got !== exp) begin error_cnt++; $display("unexpected %s: expected %h, seen %h", nm, exp, got); end
    endtask
    task automatic wr(input logic [3:0] s, input logic [46:0] d);
        {wr_en_i, wr_sel_i, wr_data_i} <= {1'b1, s, d};
        @(posedge clk_i) wr_en_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] s, input logic [46:0] e);
        rd_sel_i <= s;
        repeat (2) @(posedge clk_i);
        #1 chk("register", rd_data_o, e);
        @(posedge clk_i);
    endtask
    // request, wait bounded for the answer, then let results settle
    task automatic access(input int k);
        {fetch_i, opnd_rd_i, opnd_wr_i} <= 3'(4 >> k);
        @(posedge clk_i) {fetch_i, opnd_rd_i, opnd_wr_i} <= 3'h0;
        for (int n = 0; n < 9 && !(k > 0 ? opnd_done_o : mem_ack_i); n++) @(posedge clk_i);
        repeat (k > 0 ? 0 : 3) @(posedge clk_i);
        #1;
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 0;
        @(posedge clk_i) #1 chk("pc", pc_o, 48'h0);
        @(posedge clk_i) wr(4'h0, 47'h800000);
        wr(4'h3, {24'h123456, 23'h55});
        rd(4'h0, 47'h800055);
        rd(4'h3, {24'h123456, 23'h55});
        rd(4'h2, 47'h123456);
        wr(4'h1, 47'h7FFFC3);
        rd(4'h1, 47'hC3);
        for (int s = 4; s < 8; s++) wr(4'(s), 47'(s * 24'h111111));
        for (int s = 4; s < 7; s++) rd(4'(s), 47'(s * 24'h111111));
        rd(4'h7, 47'h7);
        io_in_i <= 24'h5A5A5A;
        wr(4'h9, 47'h0);
        rd(4'h0, 47'h5A5A5A);
        rd_sel_i <= 4'h9;
        @(posedge clk_i) rd_sel_i <= 4'h0;
        @(posedge clk_i) #1 chk("io_out", io_out_o, 48'h5A5A5A);
        @(posedge clk_i) rd_sel_i <= 4'h8;
        @(posedge clk_i) rd_sel_i <= 4'h0;
        @(posedge clk_i) #1 chk("io_out", io_out_o, 48'h5A);
        @(posedge clk_i) access(0);
        chk("instr", instr_o, 48'hA80000);
        chk("pc", pc_o, 48'h1);
        @(posedge clk_i) {shift_load_i, shift_cnt_i, branch_i, panel_pc_i} <= {9'h13C, 2'h3};
        {branch_addr_i, panel_data_i} <= {16'h0100, 16'h8001};
        @(posedge clk_i) {shift_load_i, branch_i, panel_pc_i} <= 3'h0;
        repeat (2) @(posedge clk_i);
        #1 chk("shift", shift_cnt_o, 48'h3C);
        chk("pc", pc_o, 48'h8001);
        @(posedge clk_i) access(0);
        chk("instr", instr_o, 48'h544000);
        chk("pc", pc_o, 48'h8002);
        @(posedge clk_i) access(1);
        chk("operand", opnd_rdata_o, 48'h546000A86000);
        @(posedge clk_i) access(2);
        chk("parity", parity_err_o, 48'h0);
        finish_test();
    end
endmodule
bind crs_regs crs_regs_chk i_crs_regs_chk (.*);
